// ==== src/gsr_pkg.sv ====
package gsr_pkg;
  // Sizes
  localparam int NUM_PUB  = 16;
  localparam int NUM_DS   = 16;
  localparam int NUM_SUB  = 16;
  localparam int NUM_BIN  = 40;
  localparam int MS_W     = 15;
  localparam int TAL_W    = 16;
  localparam int BOOL_W   = 8;

  // Time base
  localparam int CLK_PERIOD_NS  = 100;
  localparam int TICK_PERIOD_NS = 1000000;
  localparam int TICK_CYC = (TICK_PERIOD_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

  // Limits
  localparam logic [MS_W-1:0]  MS_MIN        = 15'h0008;
  localparam logic [MS_W-1:0]  MS_MAX        = 15'h4E20;
  localparam logic [13:0]      APPID_UNSET   = 14'h0000;
  localparam logic [11:0]      VID_NONE      = 12'h000;
  localparam logic [47:0]      MAC_BASE      = 48'h010CCD010000;
  localparam logic [15:0]      MAX_DS_BYTES  = 16'h05DC;

  // Register byte offsets
  localparam logic [7:0] OFS_CTRL     = 8'h00;
  localparam logic [7:0] OFS_INDEX    = 8'h04;
  localparam logic [7:0] OFS_PUB_TIME = 8'h08;
  localparam logic [7:0] OFS_PUB_ADDR = 8'h0C;
  localparam logic [7:0] OFS_PUB_VLAN = 8'h10;
  localparam logic [7:0] OFS_DS_LEN   = 8'h14;
  localparam logic [7:0] OFS_ROUTE    = 8'h18;
  localparam logic [7:0] OFS_QUAL     = 8'h1C;
  localparam logic [7:0] OFS_BIN_LO   = 8'h20;
  localparam logic [7:0] OFS_BIN_HI   = 8'h24;
  localparam logic [7:0] OFS_IRQ_STAT = 8'h28;
  localparam logic [7:0] OFS_IRQ_MASK = 8'h2C;
  localparam logic [7:0] OFS_PUB_ACT  = 8'h30;

  // Field positions
  localparam int CTRL_IFSEL  = 0;
  localparam int CTRL_GEN    = 1;
  localparam int TIME_STEADY = 0;
  localparam int TIME_FIRST  = 16;
  localparam int ADDR_APPID  = 0;
  localparam int ADDR_MAC    = 16;
  localparam int VLAN_VID    = 0;
  localparam int VLAN_PRIO   = 12;
  localparam int VLAN_TAG    = 15;
  localparam int VLAN_DSEL   = 16;
  localparam int VLAN_EN     = 31;
  localparam int ST_TX       = 0;
  localparam int ST_CFGERR   = 1;
  localparam int ST_QLOST    = 2;
  localparam int ST_RX       = 3;
  localparam int ST_W        = 4;

  // Reset values
  localparam logic [MS_W-1:0] RST_MS     = 15'h0008;
  localparam logic [7:0]      RST_ROUTE  = 8'h08;

  function automatic logic [MS_W-1:0] gsr_next_delay(input logic [MS_W-1:0] d,
                                                     input logic [MS_W-1:0] s);
    logic [MS_W:0] dbl;
    dbl = {d, 1'b0};
    if (dbl > {1'b0, s})
      return s;
    return dbl[MS_W-1:0];
  endfunction

  function automatic logic gsr_ms_ok(input logic [MS_W-1:0] v);
    return (v >= MS_MIN) && (v <= MS_MAX);
  endfunction

  function automatic logic [TAL_W-1:0] gsr_tal(input logic [MS_W-1:0] s);
    logic [TAL_W:0] t;
    t = {2'b00, s} + {1'b0, s, 1'b0};
    return t[TAL_W-1:0];
  endfunction
endpackage

// ==== src/gsr_sched.sv ====
`timescale 1ns/10ps
module gsr_sched (
  // Clock and reset
  input  wire logic                     hclk,
  input  wire logic                     hresetn,
  // Control
  input  wire logic                     tick,
  input  wire logic                     run,
  input  wire logic                     change,
  input  wire logic [gsr_pkg::MS_W-1:0] first_ms,
  input  wire logic [gsr_pkg::MS_W-1:0] steady_ms,
  // Request
  input  wire logic                     grant,
  output logic                          req,
  output logic                          req_new
);
  logic [gsr_pkg::MS_W-1:0] delay_r;
  logic [gsr_pkg::MS_W-1:0] cnt_r;
  logic                     active_r;
  logic                     req_r;
  logic                     new_r;

  wire                           expire = tick & active_r & (cnt_r <= 15'h0001);
  wire [gsr_pkg::MS_W-1:0] nd     = gsr_pkg::gsr_next_delay(delay_r, steady_ms);

  assign req     = req_r;
  assign req_new = new_r;

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      delay_r  <= '0;
      cnt_r    <= '0;
      active_r <= 1'b0;
      req_r    <= 1'b0;
      new_r    <= 1'b0;
    end else if (!run) begin
      delay_r  <= '0;
      cnt_r    <= '0;
      active_r <= 1'b0;
      req_r    <= 1'b0;
      new_r    <= 1'b0;
    end else begin
      if (change) begin
        active_r <= 1'b1;
        delay_r  <= first_ms;
        cnt_r    <= first_ms;
      end else if (expire) begin
        delay_r <= nd;
        cnt_r   <= nd;
      end else if (tick && active_r) begin
        cnt_r <= cnt_r - 15'h0001;
      end
      // change raises a new frame; set beats grant
      req_r <= change | expire | (req_r & ~grant);
      new_r <= change | (new_r & ~grant);
    end
  end

  chk_change_req: assert property (@(posedge hclk) disable iff (!hresetn)
    (run && change) |=> (req && req_new))
    else $error("state change did not raise a new frame request");
  chk_first_delay: assert property (@(posedge hclk) disable iff (!hresetn)
    (run && change) |=> (delay_r == $past(first_ms) && cnt_r == $past(first_ms)))
    else $error("first repeat delay not loaded");
  chk_double_cap: assert property (@(posedge hclk) disable iff (!hresetn)
    (run && !change && expire) ##1 run |->
      (delay_r == gsr_pkg::gsr_next_delay($past(delay_r), $past(steady_ms)) && req))
    else $error("repeat delay not doubled and capped");
  chk_steady_hold: assert property (@(posedge hclk) disable iff (!hresetn)
    (run && active_r && delay_r == steady_ms && !change && expire) |=>
      (delay_r == $past(steady_ms)))
    else $error("steady interval not kept");
endmodule

// ==== src/gsr_top.sv ====
// Register access over AHB-Lite and the register offsets are this design's own decisions.
`timescale 1ns/10ps
// Notes on behaviour
// - A dataset change makes each enabled message that selects that dataset send a new frame at once.
// - First repeat follows the state-change frame after the first-repeat delay.
// - Each later delay doubles the previous one, capped at the steady interval.
// - At the steady interval the frame repeats until the next change.
// - Every frame advertises allowed lifetime of three steady intervals.
// - Sixteen messages, each with its own scheduler and dataset select.
// - Sixteen datasets; any one may feed any message.
// - A dataset longer than one frame is refused for publishing.
// - One selected Ethernet interface carries all sent and received messages.
// - Frames may carry a VLAN tag with identifier and frame priority.
// - Quality is true while received and lifetime not expired, else false.
// - Received booleans and quality flags route onto forty binary registers.
// - Both delays 8 to 20000 ms, steady no less than first-repeat.
// - Application id up to 0x3FFF; zero means unconfigured.
// - VLAN id is 12 bits, zero means untagged; priority 0 to 7.
// - Destination address within the multicast range and unique per message.
module gsr_top #(
  parameter int TICK_CYC = gsr_pkg::TICK_CYC,
  parameter logic [15:0] MAX_DS_BYTES = gsr_pkg::MAX_DS_BYTES
) (
  // AHB-Lite slave
  input  wire logic        hclk,
  input  wire logic        hresetn,
  input  wire logic        hsel,
  input  wire logic [31:0] haddr,
  input  wire logic [1:0]  htrans,
  input  wire logic        hwrite,
  input  wire logic [2:0]  hsize,
  input  wire logic [31:0] hwdata,
  input  wire logic        hready,
  output logic             hreadyout,
  output logic [31:0]      hrdata,
  output logic             hresp,
  // Dataset change events
  input  wire logic [gsr_pkg::NUM_DS-1:0] ds_change,
  // Frame send requests
  output logic             tx_valid,
  input  wire logic        tx_ready,
  output logic [3:0]       tx_msg,
  output logic             tx_new,
  output logic [3:0]       tx_dataset,
  output logic [47:0]      tx_mac,
  output logic [13:0]      tx_appid,
  output logic             tx_tag,
  output logic [11:0]      tx_vid,
  output logic [2:0]       tx_prio,
  output logic [15:0]      tx_tal_ms,
  output logic             eth_if_sel,
  // Received frames
  input  wire logic        rx_valid,
  input  wire logic        rx_port,
  input  wire logic [3:0]  rx_sub,
  input  wire logic [15:0] rx_tal_ms,
  input  wire logic [7:0]  rx_bool,
  // Results
  output logic [gsr_pkg::NUM_SUB-1:0] sub_quality,
  output logic [gsr_pkg::NUM_BIN-1:0] bin_reg,
  output logic                        irq
);
  localparam int TW = $clog2(TICK_CYC);
  localparam int NP = gsr_pkg::NUM_PUB;
  localparam int NS = gsr_pkg::NUM_SUB;
  localparam int MW = gsr_pkg::MS_W;

  // Configuration storage
  logic [MW-1:0]    first_r  [NP];
  logic [MW-1:0]    steady_r [NP];
  logic [13:0]      appid_r  [NP];
  logic [8:0]       mac_r    [NP];
  logic [11:0]      vid_r    [NP];
  logic [2:0]       prio_r   [NP];
  logic             tag_r    [NP];
  logic [3:0]       dsel_r   [NP];
  logic [15:0]      dslen_r  [gsr_pkg::NUM_DS];
  logic [7:0]       route_r  [gsr_pkg::NUM_BIN];
  logic [NP-1:0]    en_r;
  logic             ifsel_r;
  logic             gen_r;
  logic [5:0]       idx_r;
  logic [gsr_pkg::ST_W-1:0] stat_r;
  logic [gsr_pkg::ST_W-1:0] mask_r;

  // Bus state
  logic             wr_pend_r;
  logic [7:0]       wr_addr_r;
  logic [31:0]      rdata_r;

  // Time base and subscriptions
  logic [TW-1:0]    tick_cnt_r;
  logic [15:0]      qcnt_r   [NS];
  logic [15:0]      qcnt_nxt [NS];
  logic [7:0]       bools_r  [NS];
  logic [NS-1:0]    qual_r;
  logic [NS-1:0]    qual_nxt;
  logic [gsr_pkg::NUM_BIN-1:0] bin_r;

  // Scheduler and transmit
  logic [NP-1:0]    req;
  logic [NP-1:0]    req_new;
  logic [NP-1:0]    grant;
  logic             txv_r;
  logic [3:0]       msg_r;
  logic             new_r;
  logic [3:0]       ds_r;
  logic [47:0]      mac_out_r;
  logic [13:0]      appid_out_r;
  logic             tag_out_r;
  logic [11:0]      vid_out_r;
  logic [2:0]       prio_out_r;
  logic [15:0]      tal_out_r;

  wire [3:0] pi        = idx_r[3:0];
  wire       ahb_take  = hsel & hready & htrans[1];
  wire       wr_ctrl   = wr_pend_r & (wr_addr_r == gsr_pkg::OFS_CTRL);
  wire       wr_index  = wr_pend_r & (wr_addr_r == gsr_pkg::OFS_INDEX);
  wire       wr_time   = wr_pend_r & (wr_addr_r == gsr_pkg::OFS_PUB_TIME);
  wire       wr_addr   = wr_pend_r & (wr_addr_r == gsr_pkg::OFS_PUB_ADDR);
  wire       wr_vlan   = wr_pend_r & (wr_addr_r == gsr_pkg::OFS_PUB_VLAN);
  wire       wr_dslen  = wr_pend_r & (wr_addr_r == gsr_pkg::OFS_DS_LEN);
  wire       wr_route  = wr_pend_r & (wr_addr_r == gsr_pkg::OFS_ROUTE);
  wire       wr_stat   = wr_pend_r & (wr_addr_r == gsr_pkg::OFS_IRQ_STAT);
  wire       wr_mask   = wr_pend_r & (wr_addr_r == gsr_pkg::OFS_IRQ_MASK);
  wire       tick      = (tick_cnt_r == TW'(TICK_CYC - 1));
  wire [3:0] new_dsel  = hwdata[gsr_pkg::VLAN_DSEL +: 4];
  wire       want_en   = hwdata[gsr_pkg::VLAN_EN];
  wire       rx_take   = rx_valid & (rx_port == ifsel_r);
  wire       tx_done   = txv_r & tx_ready;

  // Configuration checks on enabling a message and on writing a dataset length
  logic mac_dup;
  logic ds_busy;
  always_comb begin
    mac_dup = 1'b0;
    ds_busy = 1'b0;
    for (int j = 0; j < NP; j++) begin
      if (en_r[j] && (j != int'(pi)) && (mac_r[j] == mac_r[pi]))
        mac_dup = 1'b1;
      if (en_r[j] && (dsel_r[j] == pi))
        ds_busy = 1'b1;
    end
  end

  wire time_ok  = gsr_pkg::gsr_ms_ok(first_r[pi]) & gsr_pkg::gsr_ms_ok(steady_r[pi])
                  & (steady_r[pi] >= first_r[pi]);
  wire appid_ok = (appid_r[pi] != gsr_pkg::APPID_UNSET);
  wire size_ok  = (dslen_r[new_dsel] <= MAX_DS_BYTES);
  wire cfg_ok   = time_ok & appid_ok & size_ok & ~mac_dup;
  wire en_bad   = wr_vlan & want_en & ~cfg_ok;
  wire locked   = (wr_time | wr_addr) & en_r[pi];
  wire ds_bad   = wr_dslen & ds_busy;
  wire cfg_err  = en_bad | locked | ds_bad;

  // Readback mux
  logic [31:0] rd_mux;
  always_comb begin
    rd_mux = 32'h0000_0000;
    unique case (haddr[7:0])
      gsr_pkg::OFS_CTRL:     rd_mux[1:0] = {gen_r, ifsel_r};
      gsr_pkg::OFS_INDEX:    rd_mux[5:0] = idx_r;
      gsr_pkg::OFS_PUB_TIME: rd_mux = {1'b0, first_r[pi], 1'b0, steady_r[pi]};
      gsr_pkg::OFS_PUB_ADDR: rd_mux = {7'h00, mac_r[pi], 2'b00, appid_r[pi]};
      gsr_pkg::OFS_PUB_VLAN: rd_mux = {en_r[pi], 11'h000, dsel_r[pi], tag_r[pi],
                                       prio_r[pi], vid_r[pi]};
      gsr_pkg::OFS_DS_LEN:   rd_mux[15:0] = dslen_r[pi];
      gsr_pkg::OFS_ROUTE:    rd_mux[7:0] = (idx_r < 6'(gsr_pkg::NUM_BIN)) ?
                                           route_r[idx_r] : 8'h00;
      gsr_pkg::OFS_QUAL:     rd_mux[NS-1:0] = qual_r;
      gsr_pkg::OFS_BIN_LO:   rd_mux = bin_r[31:0];
      gsr_pkg::OFS_BIN_HI:   rd_mux[7:0] = bin_r[39:32];
      gsr_pkg::OFS_IRQ_STAT: rd_mux[gsr_pkg::ST_W-1:0] = stat_r;
      gsr_pkg::OFS_IRQ_MASK: rd_mux[gsr_pkg::ST_W-1:0] = mask_r;
      gsr_pkg::OFS_PUB_ACT:  rd_mux[NP-1:0] = en_r;
      default:               rd_mux = 32'h0000_0000;
    endcase
  end

  assign hreadyout = 1'b1;
  assign hresp     = 1'b0;
  assign hrdata    = rdata_r;

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      wr_pend_r <= 1'b0;
      wr_addr_r <= 8'h00;
      rdata_r   <= 32'h0000_0000;
    end else begin
      wr_pend_r <= ahb_take & hwrite & (haddr[1:0] == 2'b00);
      wr_addr_r <= haddr[7:0];
      rdata_r   <= (ahb_take && !hwrite) ? rd_mux : 32'h0000_0000;
    end
  end

  // Software-written configuration
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      ifsel_r <= 1'b0;
      gen_r   <= 1'b0;
      idx_r   <= 6'h00;
      en_r    <= '0;
      mask_r  <= '0;
      for (int i = 0; i < NP; i++) begin
        first_r[i]  <= gsr_pkg::RST_MS;
        steady_r[i] <= gsr_pkg::RST_MS;
        appid_r[i]  <= gsr_pkg::APPID_UNSET;
        mac_r[i]    <= 9'(i);
        vid_r[i]    <= gsr_pkg::VID_NONE;
        prio_r[i]   <= 3'h0;
        tag_r[i]    <= 1'b0;
        dsel_r[i]   <= 4'(i);
        dslen_r[i]  <= 16'h0000;
      end
      for (int b = 0; b < gsr_pkg::NUM_BIN; b++)
        route_r[b] <= gsr_pkg::RST_ROUTE;
    end else begin
      if (wr_ctrl) begin
        ifsel_r <= hwdata[gsr_pkg::CTRL_IFSEL];
        gen_r   <= hwdata[gsr_pkg::CTRL_GEN];
      end
      if (wr_index)
        idx_r <= hwdata[5:0];
      if (wr_time && !en_r[pi]) begin
        first_r[pi]  <= hwdata[gsr_pkg::TIME_FIRST +: MW];
        steady_r[pi] <= hwdata[gsr_pkg::TIME_STEADY +: MW];
      end
      if (wr_addr && !en_r[pi]) begin
        appid_r[pi] <= hwdata[gsr_pkg::ADDR_APPID +: 14];
        mac_r[pi]   <= hwdata[gsr_pkg::ADDR_MAC +: 9];
      end
      // VLAN tag fields; 12-bit id, 3-bit priority
      if (wr_vlan) begin
        vid_r[pi]  <= hwdata[gsr_pkg::VLAN_VID +: 12];
        prio_r[pi] <= hwdata[gsr_pkg::VLAN_PRIO +: 3];
        tag_r[pi]  <= hwdata[gsr_pkg::VLAN_TAG] &
                      (hwdata[gsr_pkg::VLAN_VID +: 12] != gsr_pkg::VID_NONE);
        dsel_r[pi] <= new_dsel;
        en_r[pi]   <= want_en & cfg_ok;
      end
      if (wr_dslen && !ds_busy)
        dslen_r[pi] <= hwdata[15:0];
      if (wr_route && (idx_r < 6'(gsr_pkg::NUM_BIN)))
        route_r[idx_r] <= hwdata[7:0];
      if (wr_mask)
        mask_r <= hwdata[gsr_pkg::ST_W-1:0];
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn)
      tick_cnt_r <= '0;
    else
      tick_cnt_r <= tick ? '0 : tick_cnt_r + TW'(1);
  end

  for (genvar g = 0; g < NP; g++) begin : g_pub
    gsr_sched u_sched (
      .hclk      (hclk),
      .hresetn   (hresetn),
      .tick      (tick),
      .run       (gen_r & en_r[g]),
      .change    (ds_change[dsel_r[g]]),
      .first_ms  (first_r[g]),
      .steady_ms (steady_r[g]),
      .grant     (grant[g]),
      .req       (req[g]),
      .req_new   (req_new[g])
    );
  end

  // Lowest-numbered pending message goes next
  logic [3:0] pick;
  logic       any_req;
  always_comb begin
    pick    = 4'h0;
    any_req = 1'b0;
    for (int i = NP - 1; i >= 0; i--) begin
      if (req[i]) begin
        pick    = 4'(i);
        any_req = 1'b1;
      end
    end
  end

  wire load = any_req & ~txv_r;
  assign grant = load ? (NP'(1) << pick) : '0;

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      txv_r       <= 1'b0;
      msg_r       <= 4'h0;
      new_r       <= 1'b0;
      ds_r        <= 4'h0;
      mac_out_r   <= 48'h0000_0000_0000;
      appid_out_r <= 14'h0000;
      tag_out_r   <= 1'b0;
      vid_out_r   <= 12'h000;
      prio_out_r  <= 3'h0;
      tal_out_r   <= 16'h0000;
    end else if (load) begin
      txv_r       <= 1'b1;
      msg_r       <= pick;
      new_r       <= req_new[pick];
      ds_r        <= dsel_r[pick];
      mac_out_r   <= gsr_pkg::MAC_BASE | {39'h0, mac_r[pick]};
      appid_out_r <= appid_r[pick];
      tag_out_r   <= tag_r[pick];
      vid_out_r   <= vid_r[pick];
      prio_out_r  <= prio_r[pick];
      tal_out_r   <= gsr_pkg::gsr_tal(steady_r[pick]);
    end else if (tx_done) begin
      txv_r <= 1'b0;
    end
  end

  assign tx_valid   = txv_r;
  assign tx_msg     = msg_r;
  assign tx_new     = new_r;
  assign tx_dataset = ds_r;
  assign tx_mac     = mac_out_r;
  assign tx_appid   = appid_out_r;
  assign tx_tag     = tag_out_r;
  assign tx_vid     = vid_out_r;
  assign tx_prio    = prio_out_r;
  assign tx_tal_ms  = tal_out_r;
  assign eth_if_sel = ifsel_r;

  // reload on receive, count down per tick
  always_comb begin
    for (int k = 0; k < NS; k++) begin
      if (rx_take && (rx_sub == 4'(k)))
        qcnt_nxt[k] = rx_tal_ms;
      else if (tick && (qcnt_r[k] != 16'h0000))
        qcnt_nxt[k] = qcnt_r[k] - 16'h0001;
      else
        qcnt_nxt[k] = qcnt_r[k];
      qual_nxt[k] = (qcnt_nxt[k] != 16'h0000);
    end
  end

  // route booleans and quality to binary registers
  logic [gsr_pkg::NUM_BIN-1:0] bin_nxt;
  always_comb begin
    for (int b = 0; b < gsr_pkg::NUM_BIN; b++)
      bin_nxt[b] = route_r[b][3] ? qual_r[route_r[b][7:4]]
                                 : bools_r[route_r[b][7:4]][route_r[b][2:0]];
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      qual_r <= '0;
      bin_r  <= '0;
      for (int k = 0; k < NS; k++) begin
        qcnt_r[k]  <= 16'h0000;
        bools_r[k] <= 8'h00;
      end
    end else begin
      qual_r <= qual_nxt;
      bin_r  <= bin_nxt;
      for (int k = 0; k < NS; k++) begin
        qcnt_r[k] <= qcnt_nxt[k];
        if (rx_take && (rx_sub == 4'(k)))
          bools_r[k] <= rx_bool;
      end
    end
  end

  assign sub_quality = qual_r;
  assign bin_reg     = bin_r;

  // Sticky events; a new event beats a same-cycle clear
  wire [gsr_pkg::ST_W-1:0] ev = {rx_take, |(qual_r & ~qual_nxt), cfg_err, tx_done};
  wire [gsr_pkg::ST_W-1:0] clr = wr_stat ? hwdata[gsr_pkg::ST_W-1:0] : '0;
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn)
      stat_r <= '0;
    else
      stat_r <= ev | (stat_r & ~clr);
  end
  assign irq = |(stat_r & mask_r);

  chk_tal_triple: assert property (@(posedge hclk) disable iff (!hresetn)
    load |=> (tx_valid && tx_tal_ms == 16'(3 * int'($past(steady_r[pick])))))
    else $error("advertised lifetime is not three steady intervals");
  chk_bad_refused: assert property (@(posedge hclk) disable iff (!hresetn)
    (wr_vlan && want_en && !time_ok) |=> (!en_r[$past(pi)] && stat_r[gsr_pkg::ST_CFGERR]))
    else $error("message enabled with bad delays");
  chk_qual_reload: assert property (@(posedge hclk) disable iff (!hresetn)
    (rx_take && rx_tal_ms != 16'h0000) |=> qual_r[$past(rx_sub)])
    else $error("received frame did not set quality");
  chk_qual_expire: assert property (@(posedge hclk) disable iff (!hresetn)
    (tick && qcnt_r[0] == 16'h0001 && !(rx_take && rx_sub == 4'h0)) |=> !qual_r[0])
    else $error("quality held after lifetime ran out");
  chk_if_ignore: assert property (@(posedge hclk) disable iff (!hresetn)
    (rx_valid && rx_port != ifsel_r && !tick) |=>
      (qcnt_r[$past(rx_sub)] == $past(qcnt_r[rx_sub])))
    else $error("frame from the unselected interface accepted");
endmodule

// ==== verif/gsr_peer.sv ====
`timescale 1ns/10ps
// Far-side stations: frame sink with back-pressure and a frame source
module gsr_peer (
  // Clock and reset
  input  wire logic        hclk,
  input  wire logic        hresetn,
  // Frame sink
  input  wire logic        stall,
  output logic             tx_ready,
  // Frame source
  output logic             rx_valid,
  output logic             rx_port,
  output logic [3:0]       rx_sub,
  output logic [15:0]      rx_tal_ms,
  output logic [7:0]       rx_bool
);
  initial begin
    {rx_valid, rx_port, rx_sub, rx_tal_ms, rx_bool} = '0;
  end
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) tx_ready <= 1'b0;
    else tx_ready <= !stall;
  end
  task automatic send(input logic p, input logic [3:0] s, input logic [15:0] t);
    @(posedge hclk);
    rx_valid <= 1'b1;
    {rx_port, rx_sub, rx_tal_ms, rx_bool} <= {p, s, t, 8'hA5};
    @(posedge hclk);
    rx_valid <= 1'b0;
    // Idle fields inverted so stale values never pass for a frame
    {rx_port, rx_sub, rx_tal_ms, rx_bool} <= ~{p, s, t, 8'hA5};
  endtask
endmodule

// ==== verif/goose_repeat_scheduler_tb.sv ====
`timescale 1ns/10ps
`define CHK(a, b) begin check_count++; if ((a) !== (b)) begin err_count++; \
  $display("MISMATCH t=%0t got=%0h exp=%0h", $time, (a), (b)); end end
module goose_repeat_scheduler_tb;
  localparam int TK = 20;
  int          err_count = 0;
  int          check_count = 0;
  int          n;
  logic        hclk = 0, hresetn = 0, hsel = 0, hwrite = 0, stall = 0;
  logic [31:0] haddr = '0, hwdata = '0, rd, hrdata;
  logic [1:0]  htrans = '0;
  logic [15:0] ds_change = '0, rx_tal_ms, tx_tal_ms, sub_quality;
  logic        hreadyout, tx_valid, tx_ready, tx_new, tx_tag, eth_if_sel, irq;
  logic        rx_valid, rx_port, hresp;
  logic [3:0]  rx_sub, tx_msg, tx_dataset;
  logic [13:0] tx_appid;
  logic [7:0]  rx_bool;
  logic [47:0] tx_mac;
  logic [11:0] tx_vid;
  logic [2:0]  tx_prio;
  logic [39:0] bin_reg;

  always #50 hclk = ~hclk;

  gsr_top #(.TICK_CYC(TK), .MAX_DS_BYTES(16'h0040)) uut (
    .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
    .hwrite(hwrite), .hsize(3'b010), .hwdata(hwdata), .hready(hreadyout),
    .hreadyout(hreadyout), .hrdata(hrdata), .hresp(hresp), .ds_change(ds_change),
    .tx_valid(tx_valid), .tx_ready(tx_ready), .tx_msg(tx_msg), .tx_new(tx_new),
    .tx_dataset(tx_dataset), .tx_mac(tx_mac), .tx_appid(tx_appid), .tx_tag(tx_tag),
    .tx_vid(tx_vid),
    .tx_prio(tx_prio), .tx_tal_ms(tx_tal_ms), .eth_if_sel(eth_if_sel),
    .rx_valid(rx_valid), .rx_port(rx_port), .rx_sub(rx_sub), .rx_tal_ms(rx_tal_ms),
    .rx_bool(rx_bool), .sub_quality(sub_quality), .bin_reg(bin_reg), .irq(irq));

  gsr_peer peer (.hclk(hclk), .hresetn(hresetn), .stall(stall), .tx_ready(tx_ready),
    .rx_valid(rx_valid), .rx_port(rx_port), .rx_sub(rx_sub), .rx_tal_ms(rx_tal_ms),
    .rx_bool(rx_bool));

  task automatic ahb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge hclk);
    {hsel, htrans, hwrite, haddr} <= {1'b1, 2'b10, w, 24'h0, a};
    do @(posedge hclk); while (hreadyout !== 1'b1);
    {hsel, htrans, hwdata} <= {1'b0, 2'b00, d};
    do @(posedge hclk); while (hreadyout !== 1'b1);
    rd = hrdata;
  endtask

  // Cycles from the last frame offer to the next one
  task automatic wait_tx();
    n = 0;
    while (tx_valid === 1'b1) begin @(negedge hclk); n++; end
    while (tx_valid !== 1'b1 && n < 3000) begin @(negedge hclk); n++; end
  endtask

  task automatic t_reset();
    @(negedge hclk);
    `CHK({hresp, tx_valid, irq, sub_quality, bin_reg}, 59'h0)
    ahb(1'b0, gsr_pkg::OFS_CTRL, 32'h0);
    `CHK(rd, 32'h0)
  endtask

  task automatic t_config();
    ahb(1'b1, gsr_pkg::OFS_CTRL, 32'h3);
    ahb(1'b1, gsr_pkg::OFS_INDEX, 32'h0);
    ahb(1'b1, gsr_pkg::OFS_PUB_TIME, 32'h0008_0014);
    ahb(1'b1, gsr_pkg::OFS_PUB_ADDR, 32'h0000_0001);
    ahb(1'b1, gsr_pkg::OFS_PUB_VLAN, 32'h8000_B005);
    ahb(1'b1, gsr_pkg::OFS_IRQ_MASK, 32'h2);
    ahb(1'b0, gsr_pkg::OFS_PUB_ACT, 32'h0);
    `CHK(rd, 32'h1)
    `CHK(eth_if_sel, 1'b1)
    ahb(1'b0, 8'h40, 32'h0);
    `CHK(rd, 32'h0)
  endtask

  // Bad delays, steady below first, unset id, shared address, oversize dataset
  task automatic t_refuse();
    logic [31:0] tm [5] = '{32'h0008_0007, 32'h0010_0008, 32'h0008_0014,
                            32'h0008_0014, 32'h0008_0014};
    logic [31:0] ad [5] = '{32'h0001_0001, 32'h0002_0001, 32'h0003_0000,
                            32'h0000_0001, 32'h0005_0001};
    for (int k = 1; k <= 5; k++) begin
      if (k == 5) begin
        ahb(1'b1, gsr_pkg::OFS_INDEX, 32'h5);
        ahb(1'b1, gsr_pkg::OFS_DS_LEN, 32'h41);
      end
      ahb(1'b1, gsr_pkg::OFS_INDEX, k);
      ahb(1'b1, gsr_pkg::OFS_PUB_TIME, tm[k-1]);
      ahb(1'b1, gsr_pkg::OFS_PUB_ADDR, ad[k-1]);
      ahb(1'b1, gsr_pkg::OFS_PUB_VLAN, 32'h8000_0000 | (k << 16));
      ahb(1'b0, gsr_pkg::OFS_PUB_ACT, 32'h0);
      `CHK(rd, 32'h1)
      `CHK(irq, 1'b1)
      ahb(1'b1, gsr_pkg::OFS_IRQ_STAT, 32'h2);
      @(negedge hclk);
      `CHK(irq, 1'b0)
    end
  endtask

  task automatic t_repeat();
    int dl [4] = '{8, 16, 20, 20};
    for (int r = 0; r < 2; r++) begin
      @(posedge hclk) ds_change <= 16'h0001;
      @(posedge hclk) ds_change <= 16'h0000;
      wait_tx();
      `CHK(n <= 3 && tx_new === 1'b1, 1'b1)
    end
    `CHK(tx_tal_ms, 16'h003C)
    `CHK(tx_mac, gsr_pkg::MAC_BASE)
    `CHK({tx_tag, tx_prio, tx_vid}, 16'hB005)
    `CHK({tx_msg, tx_dataset, tx_appid}, 22'h0001)
    foreach (dl[i]) begin
      wait_tx();
      `CHK(n > (dl[i] - 1) * TK - 3 && n <= dl[i] * TK + 3, 1'b1)
      `CHK(tx_new, 1'b0)
    end
    // Sink stalls: the steady repeat must wait, not vanish
    @(posedge hclk) stall <= 1'b1;
    wait_tx();
    repeat (3) @(negedge hclk);
    `CHK(tx_valid === 1'b1 && n > 19 * TK - 3 && n <= 20 * TK + 3, 1'b1)
    @(posedge hclk) stall <= 1'b0;
  endtask

  task automatic t_rx();
    peer.send(1'b0, 4'h0, 16'h0003);
    repeat (3) @(negedge hclk);
    `CHK(sub_quality[0], 1'b0)
    peer.send(1'b1, 4'h0, 16'h0003);
    @(negedge hclk);
    `CHK(sub_quality[0], 1'b1)
    @(negedge hclk);
    `CHK(bin_reg, {40{1'b1}})
    repeat (2 * TK) @(negedge hclk);
    peer.send(1'b1, 4'h0, 16'h0003);
    repeat (2 * TK) @(negedge hclk);
    `CHK(sub_quality[0], 1'b1)
    repeat (2 * TK) @(negedge hclk);
    `CHK(sub_quality[0], 1'b0)
    ahb(1'b0, gsr_pkg::OFS_IRQ_STAT, 32'h0);
    `CHK(rd, 32'hD)
  endtask

  task automatic test_done();
    $display("errors=%0d checks=%0d", err_count, check_count);
    if (err_count == 0 && check_count > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask

  initial begin
    repeat (2) @(posedge hclk);
    hresetn <= 1'b1;
    t_reset();
    t_config();
    t_refuse();
    t_repeat();
    t_rx();
    test_done();
  end

  // Whole run needs about 2000 cycles
  initial begin
    #2000000;
    err_count++;
    test_done();
  end
endmodule
